/* rtl/sixteen_channel_cc_unit.sv */
`timescale 1ns/1ps
// Behaviour
// - 16 channels, one-cycle resolution, eight when staggered.
// - Two independent 16-bit reloadable time bases.
// - Timer clock: prescaled system clock or timer overflow.
// - External count input can advance a time base.
// - Each channel picks timer and capture/compare.
// - Each channel owns one pin, in or out.
// - Capture latches assigned timer on pin event.
// - Every capture raises that channel's interrupt.
// - Capture edge: rising, falling, or both.
// - Compare modes match continuously, act on equality.
// - Mode 0: interrupt only, many per period.
// - Mode 1: pin toggles on every match.
// - Mode 2: interrupt only, once per period.
// - Mode 3: pin set on match, cleared on overflow.
// - Double mode: two registers toggle one pin.
// - Single event: act once, then ignore matches.
// - External timer overflow can clock either time base.
module sixteen_channel_cc_unit (
    input  wire logic                                     clk,
    input  wire logic                                     rst_n,
    input  wire logic                                     stagger_en,
    input  wire cc_pkg::tb_src_e   [cc_pkg::TB_N-1:0]     tb_src,
    input  wire logic              [cc_pkg::TB_N-1:0][15:0] tb_reload,
    input  wire logic              [cc_pkg::TB_N-1:0]     tb_load,
    input  wire logic              [15:0]                 tb_load_val,
    input  wire logic                                     gpt_ovf,
    input  wire logic                                     ext_count_in,
    input  wire cc_pkg::cc_mode_e  [cc_pkg::CH_N-1:0]     cc_mode,
    input  wire cc_pkg::edge_sel_e [cc_pkg::CH_N-1:0]     cc_edge,
    input  wire logic              [cc_pkg::CH_N-1:0]     cc_tsel,
    input  wire logic              [cc_pkg::CH_N-1:0]     cc_single,
    input  wire logic              [cc_pkg::CH_N-1:0]     cc_wr,
    input  wire logic              [15:0]                 cc_wdata,
    input  wire logic              [cc_pkg::CH_N-1:0]     cc_pin_in,
    output logic                   [cc_pkg::CH_N-1:0]     cc_pin_out,
    output logic                   [cc_pkg::CH_N-1:0]     cc_pin_oe,
    output logic                   [cc_pkg::CH_N-1:0]     cc_irq,
    output logic                   [cc_pkg::CH_N-1:0][15:0] cc_value,
    output logic                   [cc_pkg::TB_N-1:0][15:0] tb_count,
    output logic                   [cc_pkg::TB_N-1:0]     tb_ovf
);
    import cc_pkg::*;

    // ****************************************
    // Shared clock dividers
    // ****************************************
    logic [PRE_W-1:0]  pre_r;
    logic [STAG_W-1:0] stag_r;
    logic              ext_prev_r;
    logic              ext_rise;
    logic              tick_gate;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_r <= PRE_RST;
        end else begin
            pre_r <= pre_r + 4'h1;
        end
    end

    // In staggered operation the channels are served one slot in eight,
    // so the time bases may only advance once every eight cycles.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stag_r <= STAG_RST;
        end else begin
            stag_r <= stag_r + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_prev_r <= 1'b0;
        end else begin
            ext_prev_r <= ext_count_in;
        end
    end

    assign ext_rise  = ext_count_in & ~ext_prev_r;
    assign tick_gate = !stagger_en || (stag_r == STAG_LAST);

    // ****************************************
    // Time bases
    // ****************************************
    logic [CW-1:0] cnt_r  [TB_N];
    logic          tupd_r [TB_N];
    logic          tovf_r [TB_N];

    for (genvar t = 0; t < TB_N; t++) begin : g_tb
        logic raw;
        logic tick;

        always_comb begin
            case (tb_src[t])
                SRC_DIV1:  raw = 1'b1;
                SRC_DIV2:  raw = pre_r[0];
                SRC_DIV4:  raw = &pre_r[1:0];
                SRC_DIV8:  raw = &pre_r[2:0];
                SRC_DIV16: raw = &pre_r[3:0];
                SRC_GPT:   raw = gpt_ovf;
                SRC_EXT:   raw = ext_rise;
                default:   raw = 1'b0;
            endcase
            tick = raw && tick_gate;
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                cnt_r[t] <= CNT_RST;
            end else if (tb_load[t]) begin
                cnt_r[t] <= tb_load_val;
            end else if (tick) begin
                if (cnt_r[t] == CNT_MAX) begin
                    cnt_r[t] <= tb_reload[t];
                end else begin
                    cnt_r[t] <= cnt_r[t] + 16'h0001;
                end
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                tupd_r[t] <= 1'b0;
            end else begin
                tupd_r[t] <= tick || tb_load[t];
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                tovf_r[t] <= 1'b0;
            end else begin
                tovf_r[t] <= tick && !tb_load[t] && (cnt_r[t] == CNT_MAX);
            end
        end

        assign tb_count[t] = cnt_r[t];
        assign tb_ovf[t]   = tovf_r[t];

        a_reload_ovf: assert property (@(posedge clk) disable iff (!rst_n)
            (tick && !tb_load[t] && cnt_r[t] == CNT_MAX)
            |=> (cnt_r[t] == $past(tb_reload[t])) && tovf_r[t])
            else $error("time base did not reload on overflow");

        a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
            (tick && !tb_load[t] && cnt_r[t] != CNT_MAX)
            |=> cnt_r[t] == $past(cnt_r[t]) + 16'h0001)
            else $error("time base did not step by one");

        a_stagger_rate: assert property (@(posedge clk) disable iff (!rst_n)
            (stagger_en && stag_r != STAG_LAST && !tb_load[t])
            |=> !tupd_r[t])
            else $error("time base advanced off its stagger slot");

        a_full_rate: assert property (@(posedge clk) disable iff (!rst_n)
            (!stagger_en && tb_src[t] == SRC_DIV1)
            |=> tupd_r[t])
            else $error("undivided time base missed a cycle");

        a_gpt_source: assert property (@(posedge clk) disable iff (!rst_n)
            (tb_src[t] == SRC_GPT && !stagger_en && gpt_ovf)
            |=> tupd_r[t])
            else $error("external timer overflow did not clock the time base");

        a_ext_count: assert property (@(posedge clk) disable iff (!rst_n)
            (tb_src[t] == SRC_EXT && !stagger_en && !ext_count_in)
            ##1 (ext_count_in && tb_src[t] == SRC_EXT)
            |=> tupd_r[t])
            else $error("count input edge did not advance the time base");

        a_stopped: assert property (@(posedge clk) disable iff (!rst_n)
            (tb_src[t] == SRC_STOP && !tb_load[t])
            |=> $stable(cnt_r[t]))
            else $error("stopped time base moved");

        a_load_value: assert property (@(posedge clk) disable iff (!rst_n)
            tb_load[t] |=> cnt_r[t] == $past(tb_load_val) && tupd_r[t])
            else $error("time base did not take the loaded value");
    end

    // ****************************************
    // Channel array
    // ****************************************
    cc_chan_if chif [CH_N] ();

    for (genvar g = 0; g < CH_N; g++) begin : g_ch
        assign chif[g].tval     = cc_tsel[g] ? cnt_r[1] : cnt_r[0];
        assign chif[g].tupd     = cc_tsel[g] ? tupd_r[1] : tupd_r[0];
        assign chif[g].tovf     = cc_tsel[g] ? tovf_r[1] : tovf_r[0];
        assign chif[g].pin_in   = cc_pin_in[g];
        assign chif[g].mode     = cc_mode[g];
        assign chif[g].edge_sel = cc_edge[g];
        assign chif[g].single   = cc_single[g];
        assign chif[g].wr       = cc_wr[g];
        assign chif[g].wdata    = cc_wdata;

        // Channel g below the pair offset owns the shared pin in double mode;
        // its partner g+8 only supplies match events.
        if (g < PAIR_OFS) begin : g_low
            assign chif[g].partner_match = (cc_mode[g + PAIR_OFS] == CM_DOUBLE) && chif[g + PAIR_OFS].match;
        end else begin : g_high
            assign chif[g].partner_match = 1'b0;
        end

        cc_channel #(
            .PIN_OWNER (g < PAIR_OFS)
        ) u_ch (
            .clk   (clk),
            .rst_n (rst_n),
            .ch    (chif[g])
        );

        assign cc_pin_out[g] = chif[g].pin_out;
        assign cc_pin_oe[g]  = chif[g].pin_oe;
        assign cc_irq[g]     = chif[g].irq;
        assign cc_value[g]   = chif[g].value;

        a_assign_timer: assert property (@(posedge clk) disable iff (!rst_n)
            (cc_mode[g] == CM_CAPTURE && !cc_pin_in[g])
            ##1 (cc_pin_in[g] && cc_edge[g][0] && cc_mode[g] == CM_CAPTURE)
            |=> cc_value[g] == $past(cc_tsel[g] ? tb_count[1] : tb_count[0]) && cc_irq[g])
            else $error("capture took the wrong time base");
    end

    // ****************************************
    // Scenario coverage
    // ****************************************
    c_capture: cover property (@(posedge clk) disable iff (!rst_n)
        cc_mode[2] == CM_CAPTURE && cc_irq[2]);
    c_overflow: cover property (@(posedge clk) disable iff (!rst_n)
        tovf_r[0] ##1 tupd_r[0]);
    c_mode3_pulse: cover property (@(posedge clk) disable iff (!rst_n)
        cc_mode[7] == CM_CMP3 && $rose(cc_pin_out[7]));
    c_double_pin: cover property (@(posedge clk) disable iff (!rst_n)
        cc_mode[1] == CM_DOUBLE && cc_irq[9] && !cc_irq[1]);
    c_staggered: cover property (@(posedge clk) disable iff (!rst_n)
        stagger_en && tupd_r[0]);
endmodule : sixteen_channel_cc_unit

/* include/cc_pkg.sv */
package cc_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int CH_N      = 16;
    localparam int TB_N      = 2;
    localparam int CW        = 16;
    localparam int PAIR_OFS  = 8;
    localparam int PRE_W     = 4;
    localparam int STAG_W    = 3;

    // ****************************************
    // Reset values and limits
    // ****************************************
    localparam logic [CW-1:0]     CNT_MAX    = 16'hFFFF;
    localparam logic [CW-1:0]     CNT_RST    = 16'h0000;
    localparam logic [CW-1:0]     VALUE_RST  = 16'h0000;
    localparam logic [PRE_W-1:0]  PRE_RST    = 4'h0;
    localparam logic [STAG_W-1:0] STAG_RST   = 3'h0;
    localparam logic [STAG_W-1:0] STAG_LAST  = 3'h7;
    localparam logic              PIN_RST    = 1'b0;

    // ****************************************
    // Channel modes, edges and clock sources
    // ****************************************
    typedef enum logic [6:0] {
        CM_OFF     = 7'h01,
        CM_CAPTURE = 7'h02,
        CM_CMP0    = 7'h04,
        CM_CMP1    = 7'h08,
        CM_CMP2    = 7'h10,
        CM_CMP3    = 7'h20,
        CM_DOUBLE  = 7'h40
    } cc_mode_e;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_sel_e;

    typedef enum logic [2:0] {
        SRC_DIV1  = 3'h0,
        SRC_DIV2  = 3'h1,
        SRC_DIV4  = 3'h2,
        SRC_DIV8  = 3'h3,
        SRC_DIV16 = 3'h4,
        SRC_GPT   = 3'h5,
        SRC_EXT   = 3'h6,
        SRC_STOP  = 3'h7
    } tb_src_e;
endpackage : cc_pkg

/* include/cc_chan_if.sv */
`timescale 1ns/1ps
interface cc_chan_if;
    import cc_pkg::*;
    logic [CW-1:0] tval;
    logic          tupd;
    logic          tovf;
    logic          pin_in;
    cc_mode_e      mode;
    edge_sel_e     edge_sel;
    logic          single;
    logic          wr;
    logic [CW-1:0] wdata;
    logic          partner_match;
    logic [CW-1:0] value;
    logic          pin_out;
    logic          pin_oe;
    logic          irq;
    logic          match;
    modport unit (output tval, tupd, tovf, pin_in, mode, edge_sel, single, wr, wdata, partner_match,
                  input value, pin_out, pin_oe, irq, match);
    modport chan (input tval, tupd, tovf, pin_in, mode, edge_sel, single, wr, wdata, partner_match,
                  output value, pin_out, pin_oe, irq, match);
endinterface : cc_chan_if

/* rtl/cc_channel.sv */
`timescale 1ns/1ps
module cc_channel #(
    parameter bit PIN_OWNER = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    cc_chan_if.chan  ch
);
    import cc_pkg::*;

    logic [CW-1:0] value_r;
    logic          pin_r;
    logic          oe_r;
    logic          irq_r;
    logic          done_r;
    logic          fired_r;
    logic          prev_r;
    logic          rise;
    logic          fall;
    logic          cap_ev;
    logic          is_cmp;
    logic          once;
    logic          act;
    logic          dbl_ev;

    always_comb begin
        rise   = ch.pin_in & ~prev_r;
        fall   = ~ch.pin_in & prev_r;
        cap_ev = (ch.mode == CM_CAPTURE) && ((ch.edge_sel[0] && rise) || (ch.edge_sel[1] && fall));
        is_cmp = ch.mode inside {CM_CMP0, CM_CMP1, CM_CMP2, CM_CMP3, CM_DOUBLE};
        once   = ch.mode inside {CM_CMP2, CM_CMP3};
        act    = is_cmp && ch.tupd && (ch.tval == value_r) && !done_r && !(once && fired_r);
        dbl_ev = PIN_OWNER && (ch.mode == CM_DOUBLE) && (act || (ch.partner_match && !done_r));
    end

    assign ch.match   = act;
    assign ch.value   = value_r;
    assign ch.pin_out = pin_r;
    assign ch.pin_oe  = oe_r;
    assign ch.irq     = irq_r;

    // Capture has priority over a software write in the same cycle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            value_r <= VALUE_RST;
        end else if (cap_ev) begin
            value_r <= ch.tval;
        end else if (ch.wr) begin
            value_r <= ch.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_r  <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            irq_r  <= cap_ev || act;
            prev_r <= ch.pin_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_r <= PIN_RST;
        end else if (((ch.mode == CM_CMP1) && act) || dbl_ev) begin
            pin_r <= ~pin_r;
        end else if ((ch.mode == CM_CMP3) && act) begin
            pin_r <= 1'b1;
        end else if ((ch.mode == CM_CMP3) && ch.tovf) begin
            pin_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= (ch.mode inside {CM_CMP1, CM_CMP3}) || (PIN_OWNER && (ch.mode == CM_DOUBLE));
        end
    end

    // The stop flag is set by hardware and wins over a clearing write.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_r <= 1'b0;
        end else if (ch.single && (act || dbl_ev)) begin
            done_r <= 1'b1;
        end else if (ch.wr || !ch.single) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fired_r <= 1'b0;
        end else if (act) begin
            fired_r <= 1'b1;
        end else if (ch.tovf) begin
            fired_r <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_capture_latch: assert property (cap_ev |=> ch.value == $past(ch.tval))
        else $error("capture did not latch the timer");
    a_capture_irq: assert property (cap_ev |=> ch.irq)
        else $error("capture raised no interrupt");
    a_mode0_quiet: assert property ((ch.mode == CM_CMP0) |=> ch.pin_out == $past(ch.pin_out))
        else $error("mode 0 changed the pin");
    a_toggle_match: assert property ((ch.mode == CM_CMP1 && act) |=> ch.pin_out != $past(ch.pin_out))
        else $error("mode 1 match did not toggle");
    a_once_period: assert property ((ch.mode == CM_CMP2 && fired_r) |=> !ch.irq)
        else $error("second mode 2 interrupt in one period");
    a_mode3_pin: assert property ((ch.mode == CM_CMP3 && ch.tovf && !act) |=> !ch.pin_out)
        else $error("mode 3 pin not cleared on overflow");
    a_double_toggle: assert property ((PIN_OWNER && ch.mode == CM_DOUBLE && ch.partner_match && !done_r)
        |=> ch.pin_out != $past(ch.pin_out))
        else $error("partner match did not toggle shared pin");
    a_single_stop: assert property ((ch.single && done_r && !ch.wr && is_cmp) |=> !ch.irq)
        else $error("single event channel acted again");
    a_capture_input: assert property ((ch.mode == CM_CAPTURE) |=> !ch.pin_oe)
        else $error("capture channel drives its pin");
endmodule : cc_channel

/* bench/pin_partner.sv */
`timescale 1ns/1ps
module pin_partner (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] pin_lvl,
    input  wire logic        gpt_req,
    input  wire logic        ext_lvl,
    output logic      [15:0] pin_in,
    output logic             gpt_ovf,
    output logic             ext_count_in
);
    // ****************************************
    // Far-side drivers
    // ****************************************
    // Levels change only just after an edge, so each one lasts whole cycles.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_in       <= 16'h0000;
            gpt_ovf      <= 1'b0;
            ext_count_in <= 1'b0;
        end else begin
            pin_in       <= pin_lvl;
            gpt_ovf      <= gpt_req & ~gpt_ovf;
            ext_count_in <= ext_lvl;
        end
    end
endmodule : pin_partner

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import cc_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic                  clk, rst_n, stagger_en, gpt_ovf, ext_count_in, gpt_req, ext_lvl;
    tb_src_e   [1:0]       tb_src;
    logic      [1:0][15:0] tb_reload, tb_count;
    logic      [1:0]       tb_load, tb_ovf;
    logic      [15:0]      tb_load_val, cc_wdata, cc_tsel, cc_single, cc_wr, cc_pin_in;
    logic      [15:0]      pin_out, pin_oe, irq, pin_lvl;
    cc_mode_e  [15:0]      cc_mode;
    edge_sel_e [15:0]      cc_edge;
    logic      [15:0][15:0] cc_value;
    int                    num_errors = 0;
    int                    checks_done = 0;

    sixteen_channel_cc_unit sixteen_channel_cc_unit_inst (
        .clk(clk), .rst_n(rst_n), .stagger_en(stagger_en), .tb_src(tb_src), .tb_reload(tb_reload),
        .tb_load(tb_load), .tb_load_val(tb_load_val), .gpt_ovf(gpt_ovf), .ext_count_in(ext_count_in),
        .cc_mode(cc_mode), .cc_edge(cc_edge), .cc_tsel(cc_tsel), .cc_single(cc_single), .cc_wr(cc_wr),
        .cc_wdata(cc_wdata), .cc_pin_in(cc_pin_in), .cc_pin_out(pin_out), .cc_pin_oe(pin_oe),
        .cc_irq(irq), .cc_value(cc_value), .tb_count(tb_count), .tb_ovf(tb_ovf));

    pin_partner pin_partner_inst (
        .clk(clk), .rst_n(rst_n), .pin_lvl(pin_lvl), .gpt_req(gpt_req), .ext_lvl(ext_lvl),
        .pin_in(cc_pin_in), .gpt_ovf(gpt_ovf), .ext_count_in(ext_count_in));

    always #5 clk = ~clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finish_test;
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic give_up;
        check(16'h0000, 16'hFFFF);
        finish_test();
    endtask : give_up

    task automatic load_tb(input logic [15:0] v);
        @(posedge clk);
        tb_load[0]  <= 1'b1;
        tb_load_val <= v;
        @(posedge clk);
        tb_load[0]  <= 1'b0;
    endtask : load_tb

    task automatic write_val(input int ch, input logic [15:0] v);
        @(posedge clk);
        cc_wr[ch] <= 1'b1;
        cc_wdata  <= v;
        @(posedge clk);
        cc_wr[ch] <= 1'b0;
    endtask : write_val

    task automatic wait_irq(input int ch, input int bound);
        int n;
        n = 0;
        @(negedge clk);
        while (irq[ch] !== 1'b1) begin
            n++;
            if (n > bound) give_up();
            @(negedge clk);
        end
    endtask : wait_irq

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_ovf;
        int n;
        load_tb(16'hFFFD);
        n = 0;
        @(negedge clk);
        while (tb_ovf[0] !== 1'b1) begin
            n++;
            if (n > 10) give_up();
            @(negedge clk);
        end
        check(16'(n), 16'h0003);
        check(tb_count[0], 16'hFFF0);
        @(negedge clk);
        check(tb_count[0], 16'hFFF1);
        check(16'(tb_ovf[0]), 16'h0000);
    endtask : t_ovf

    task automatic t_rate(input tb_src_e src, input logic stag, input int div);
        logic [15:0] c;
        @(posedge clk);
        tb_src[0]  <= src;
        stagger_en <= stag;
        load_tb(16'h0000);
        repeat (2) @(negedge clk);
        c = tb_count[0];
        repeat (64) @(negedge clk);
        check(tb_count[0] - c, 16'(64 / div));
    endtask : t_rate

    task automatic t_ext_src(input tb_src_e src);
        logic [15:0] c;
        int k;
        @(posedge clk);
        tb_src[1] <= src;
        repeat (2) @(negedge clk);
        c = tb_count[1];
        for (k = 0; k < 3; k++) begin
            @(posedge clk);
            gpt_req <= (src == SRC_GPT);
            ext_lvl <= 1'b1;
            @(posedge clk);
            gpt_req <= 1'b0;
            ext_lvl <= 1'b0;
            repeat (3) @(posedge clk);
        end
        @(posedge clk);
        tb_src[1] <= SRC_STOP;
        repeat (2) @(negedge clk);
        check(tb_count[1] - c, 16'h0003);
    endtask : t_ext_src

    task automatic t_cap(input int ch, input logic ts, input edge_sel_e es, input int nexp);
        logic [15:0] c;
        int n, k;
        n = 0;
        @(posedge clk);
        cc_mode[ch] <= CM_CAPTURE;
        cc_edge[ch] <= es;
        cc_tsel[ch] <= ts;
        for (k = 0; k < 2; k++) begin
            repeat (3) @(posedge clk);
            pin_lvl[ch] <= ~pin_lvl[ch];
            @(posedge clk);
            @(negedge clk);
            c = tb_count[ts];
            @(negedge clk);
            if (irq[ch] === 1'b1) begin
                n++;
                check(cc_value[ch], c);
            end
        end
        check(16'(n), 16'(nexp));
    endtask : t_cap

    task automatic t_cmp(input int ch, input cc_mode_e m, input logic s, input int n2,
                         input logic p1, input logic p2);
        int n, k;
        @(posedge clk);
        cc_mode[ch]   <= m;
        cc_tsel[ch]   <= 1'b0;
        cc_single[ch] <= s;
        write_val(ch, 16'hFF40);
        load_tb(16'hFF30);
        wait_irq(ch, 30);
        check(tb_count[0], 16'hFF41);
        check(16'(pin_out[ch]), 16'(p1));
        load_tb(16'hFF30);
        n = 0;
        for (k = 0; k < 30; k++) begin
            @(negedge clk);
            if (irq[ch] === 1'b1) n++;
        end
        check(16'(n), 16'(n2));
        check(16'(pin_out[ch]), 16'(p2));
        check(16'(pin_oe[ch]), 16'(m == CM_CMP1 || m == CM_CMP3));
        if (m == CM_CMP3) begin
            k = 0;
            while (tb_ovf[0] !== 1'b1) begin
                k++;
                if (k > 300) give_up();
                @(negedge clk);
            end
            repeat (2) @(negedge clk);
            check(16'(pin_out[ch]), 16'h0000);
        end
    endtask : t_cmp

    task automatic t_double;
        @(posedge clk);
        cc_mode[1] <= CM_DOUBLE;
        cc_mode[9] <= CM_DOUBLE;
        write_val(1, 16'hFF40);
        write_val(9, 16'hFF50);
        load_tb(16'hFF30);
        wait_irq(1, 30);
        check(16'(pin_out[1]), 16'h0001);
        check(16'(pin_oe[1]), 16'h0001);
        wait_irq(9, 30);
        check(tb_count[0], 16'hFF51);
        check(16'(pin_out[1]), 16'h0000);
    endtask : t_double

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        stagger_en = 1'b0;
        tb_src[0] = SRC_STOP;
        tb_src[1] = SRC_STOP;
        tb_reload = '0;
        tb_load = '0;
        tb_load_val = '0;
        cc_tsel = '0;
        cc_single = '0;
        cc_wr = '0;
        cc_wdata = '0;
        pin_lvl = '0;
        gpt_req = 1'b0;
        ext_lvl = 1'b0;
        foreach (cc_mode[i]) begin
            cc_mode[i] = CM_OFF;
            cc_edge[i] = EDGE_NONE;
        end
        repeat (7) @(posedge clk);
        @(negedge clk);
        check(tb_count[0], 16'h0000);
        check(cc_value[3], 16'h0000);
        check(pin_out | pin_oe | irq, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        tb_src[0] <= SRC_DIV1;
        tb_reload[0] <= 16'hFFF0;
        t_ovf();
        t_rate(SRC_DIV1, 1'b0, 1);
        t_rate(SRC_DIV2, 1'b0, 2);
        t_rate(SRC_DIV4, 1'b0, 4);
        t_rate(SRC_DIV8, 1'b0, 8);
        t_rate(SRC_DIV16, 1'b0, 16);
        t_rate(SRC_DIV1, 1'b1, 8);
        t_rate(SRC_DIV1, 1'b0, 1);
        t_ext_src(SRC_GPT);
        t_ext_src(SRC_EXT);
        t_cap(2, 1'b0, EDGE_RISE, 1);
        t_cap(2, 1'b0, EDGE_FALL, 1);
        t_cap(2, 1'b0, EDGE_BOTH, 2);
        t_cap(2, 1'b0, EDGE_NONE, 0);
        t_cap(10, 1'b1, EDGE_BOTH, 2);
        @(posedge clk);
        tb_reload[0] <= 16'hFF00;
        t_cmp(4, CM_CMP0, 1'b0, 1, 1'b0, 1'b0);
        t_cmp(5, CM_CMP1, 1'b0, 1, 1'b1, 1'b0);
        t_cmp(6, CM_CMP2, 1'b0, 0, 1'b0, 1'b0);
        t_cmp(7, CM_CMP3, 1'b0, 0, 1'b1, 1'b1);
        t_cmp(3, CM_CMP1, 1'b1, 0, 1'b1, 1'b1);
        t_double();
        finish_test();
    end
endmodule : tb_top
